// ===== design/pmlc_pkg.sv
// package: offsets, field positions, reset values for the misc/link enhancement registers
package pmlc_pkg;
  localparam logic [7:0] PMLC_MISC_OFS = 8'hf0;
  localparam logic [7:0] PMLC_LINK_OFS = 8'hf4;
  localparam logic [31:0] PMLC_MISC_RST = 32'h00002400;
  localparam logic [31:0] PMLC_LINK_RST = 32'h00001000;
  // writable bit masks; everything else reads zero
  localparam logic [31:0] PMLC_MISC_WMASK = 32'h0000a40f;
  localparam logic [31:0] PMLC_LINK_WMASK = 32'h00003386;
  // misc field positions
  localparam int PMLC_B_COLD = 15;
  localparam int PMLC_B_WD2 = 13;
  localparam int PMLC_B_D2 = 10;
  localparam int PMLC_B_RSV3 = 3;
  localparam int PMLC_B_LGATE = 2;
  localparam int PMLC_B_HGATE = 1;
  localparam int PMLC_B_KEEP = 0;
  // link field positions
  localparam int PMLC_B_THR_HI = 13;
  localparam int PMLC_B_THR_LO = 12;
  localparam int PMLC_B_AUDIO = 9;
  localparam int PMLC_B_VIDEO = 8;
  localparam int PMLC_B_PRIO = 7;
  localparam int PMLC_B_IDLE = 2;
  localparam int PMLC_B_ACCEL = 1;
  // transmit threshold encodings
  localparam logic [1:0] PMLC_THR_2K = 2'h0;
  localparam logic [1:0] PMLC_THR_1K7 = 2'h1;
  localparam logic [1:0] PMLC_THR_1K = 2'h2;
  localparam logic [1:0] PMLC_THR_512 = 2'h3;
  // stream format codes
  localparam logic [5:0] PMLC_FMT_AUDIO = 6'h10;
  localparam logic [5:0] PMLC_FMT_VIDEO = 6'h00;
endpackage : pmlc_pkg

// ===== design/pmlc_en_if.sv
// interface carrying the raw link register to the apply stage and gated enables out of it
`timescale 1ns/1ps
interface pmlc_en_if;
  logic [31:0] link_raw;
  logic master_en;
  logic [1:0] thr_sel;
  logic audio_en;
  logic video_en;
  logic prio_en;
  logic idle_en;
  logic accel_en;
  modport src (output link_raw, output master_en);
  modport dst (input link_raw, input master_en, output thr_sel, output audio_en,
               output video_en, output prio_en, output idle_en, output accel_en);
endinterface : pmlc_en_if

// ===== design/pmlc_apply.sv
// gating of link enhancement fields by the phy enhancement master enable
`timescale 1ns/1ps
module pmlc_apply
  import pmlc_pkg::*;
(
  pmlc_en_if.dst en // raw register in, gated enables out
);
  // inactive when the master enable is low; threshold falls back to store-and-forward
  assign en.thr_sel = en.master_en ? en.link_raw[PMLC_B_THR_HI:PMLC_B_THR_LO]
                                   : PMLC_THR_2K;
  assign en.audio_en = en.master_en & en.link_raw[PMLC_B_AUDIO];
  assign en.video_en = en.master_en & en.link_raw[PMLC_B_VIDEO];
  assign en.prio_en = en.master_en & en.link_raw[PMLC_B_PRIO];
  assign en.idle_en = en.master_en & en.link_raw[PMLC_B_IDLE];
  assign en.accel_en = en.master_en & en.link_raw[PMLC_B_ACCEL];
endmodule : pmlc_apply

// ===== design/pmlc_regs.sv
// register bank: misc power/clock config and link enhancement control over avalon-mm
//
// Contract
// - misc reserved bits 31-16, 14, 12-11, 9-4 read zero
// - bit 15 writable, drives wake-from-cold-off capability field
// - bit 13 writable, drives wake-from-doze-two capability; clear means unsupported
// - bit 10 writable, drives doze-two state capability; clear means unsupported
// - capability bits survive host reset and internal d3-to-d0 reset
// - bit 3 writable spare, resets to zero, no function
// - bit 2 set bypasses internal link clock gating
// - bit 1 set bypasses internal host clock gating
// - bit 0 set asks clock be kept running; clear lets host stop it
// - link enhance bits load from software or from eeprom autoload
// - enhancement bits act only while phy enhance master enable is set
// - bits 13-12 select initial transmit threshold; underrun retry uses 2k
// - bit 9 audio fmt 10h, bit 8 video fmt 00h timestamp enhancement
// - bits 7,2,1 priority, idle, accel; reserved link bits read zero
`timescale 1ns/1ps
module pmlc_regs
  import pmlc_pkg::*;
(
  input wire logic clk_i, // host clock, 40 mhz
  input wire logic reset_i, // synchronous host reset, active high
  input wire logic pm_int_reset_i, // internal reset from d3-to-d0 transition
  input wire logic [7:0] avs_address_i, // byte address
  input wire logic avs_read_i, // read request
  input wire logic avs_write_i, // write request
  input wire logic [3:0] avs_byteenable_i, // byte lanes
  input wire logic [31:0] avs_writedata_i, // write data
  output logic [31:0] avs_readdata_o, // read data
  output logic avs_waitrequest_o, // stall, low on answer cycle
  input wire logic eep_load_i, // eeprom autoload strobe, one cycle
  input wire logic [31:0] eep_data_i, // eeprom enhancement word
  input wire logic phy_enhance_master_en_i, // from host controller control reg
  input wire logic underrun_i, // transmit fifo underrun event
  input wire logic tx_done_i, // packet sent, ends retry threshold
  output logic wake_from_cold_off_cap_o, // capability field
  output logic wake_from_doze_two_cap_o, // capability field
  output logic doze_two_state_cap_o, // capability field
  output logic link_clk_gate_bypass_o, // disable link clock gating
  output logic host_clk_gate_bypass_o, // disable host clock gating
  output logic keep_clk_run_o, // request clock always running
  output logic [1:0] tx_thresh_o, // active transmit threshold
  output logic audio_timestamp_enh_en_o, // audio stream ts enhancement
  output logic video_timestamp_enh_en_o, // video stream ts enhancement
  output logic [5:0] ts_fmt_audio_o, // format code matched for audio
  output logic [5:0] ts_fmt_video_o, // format code matched for video
  output logic async_prio_en_o, // asynchronous priority requests
  output logic insert_idle_en_o, // idle insertion
  output logic accel_en_o // acceleration enhancements
);
  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [31:0] cap_q, cap_d; // sticky capability bits only
  logic [31:0] ctl_q, ctl_d; // ordinary misc bits
  logic [31:0] link_q, link_d;
  logic sticky_init_q = 1'b0; // power-up value; set once and never cleared again
  logic ack_q;
  logic [31:0] rdata_q, rdata_d;
  logic retry_q, retry_d;
  logic [31:0] be_mask;
  logic hit_misc, hit_link, req, wr_misc, wr_link;
  logic [31:0] misc_rd;
  localparam logic [31:0] CAP_MASK = (32'h1 << PMLC_B_COLD) | (32'h1 << PMLC_B_WD2)
                                   | (32'h1 << PMLC_B_D2);
  localparam logic [31:0] CTL_MASK = PMLC_MISC_WMASK & ~CAP_MASK;

  // ---------------------------------------------------------------
  // decode; one wait cycle, answer on the second cycle of a request
  // ---------------------------------------------------------------
  assign req = (avs_read_i | avs_write_i) & ~ack_q;
  assign hit_misc = (avs_address_i == PMLC_MISC_OFS);
  assign hit_link = (avs_address_i == PMLC_LINK_OFS);
  assign wr_misc = avs_write_i & ack_q & hit_misc;
  assign wr_link = avs_write_i & ack_q & hit_link;
  assign be_mask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                    {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  assign misc_rd = (cap_q & CAP_MASK) | (ctl_q & CTL_MASK);

  // next values; byte-lane masked writes
  assign cap_d = wr_misc ? ((cap_q & ~be_mask) | (avs_writedata_i & be_mask)) & CAP_MASK
                         : cap_q;
  assign ctl_d = wr_misc ? ((ctl_q & ~be_mask) | (avs_writedata_i & be_mask)) & CTL_MASK
                         : ctl_q;
  // eeprom load wins over software in the same cycle: it is the power-on image
  assign link_d = eep_load_i ? (eep_data_i & PMLC_LINK_WMASK)
                : wr_link ? ((link_q & ~be_mask) | (avs_writedata_i & be_mask))
                            & PMLC_LINK_WMASK
                : link_q;
  // unmapped addresses read zero and ignore writes
  assign rdata_d = hit_misc ? misc_rd : hit_link ? link_q : 32'h0;
  // underrun forces store-and-forward until the packet goes out; set beats clear
  assign retry_d = underrun_i | (retry_q & ~tx_done_i);

  // ---------------------------------------------------------------
  // sticky capability bits: no reset, defaults loaded once at power-up
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!sticky_init_q) begin
      cap_q <= PMLC_MISC_RST & CAP_MASK;
    end else begin
      cap_q <= cap_d;
    end
  end

  // init flag: low only at power-up, so no later reset can reload the defaults
  always_ff @(posedge clk_i) begin
    sticky_init_q <= 1'b1;
  end

  // ordinary registers
  always_ff @(posedge clk_i) begin
    if (reset_i || pm_int_reset_i) begin
      ctl_q <= PMLC_MISC_RST & CTL_MASK;
      link_q <= PMLC_LINK_RST;
      retry_q <= 1'b0;
    end else begin
      ctl_q <= ctl_d;
      link_q <= link_d;
      retry_q <= retry_d;
    end
  end

  // bus answer; waitrequest is its own flop so the pin has no gate behind it
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ack_q <= 1'b0;
      avs_waitrequest_o <= 1'b1;
      rdata_q <= 32'h0;
    end else begin
      ack_q <= req;
      avs_waitrequest_o <= ~req;
      rdata_q <= rdata_d;
    end
  end
  assign avs_readdata_o = rdata_q;

  // ---------------------------------------------------------------
  // enhancement gating
  // ---------------------------------------------------------------
  pmlc_en_if en_if ();
  assign en_if.link_raw = link_q;
  assign en_if.master_en = phy_enhance_master_en_i;
  pmlc_apply u_apply (
    .en(en_if.dst)
  );

  // ---------------------------------------------------------------
  // output flops
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      tx_thresh_o <= PMLC_THR_2K;
      audio_timestamp_enh_en_o <= 1'b0;
      video_timestamp_enh_en_o <= 1'b0;
      async_prio_en_o <= 1'b0;
      insert_idle_en_o <= 1'b0;
      accel_en_o <= 1'b0;
      link_clk_gate_bypass_o <= 1'b0;
      host_clk_gate_bypass_o <= 1'b0;
      keep_clk_run_o <= 1'b0;
    end else begin
      tx_thresh_o <= retry_q ? PMLC_THR_2K : en_if.thr_sel;
      audio_timestamp_enh_en_o <= en_if.audio_en;
      video_timestamp_enh_en_o <= en_if.video_en;
      async_prio_en_o <= en_if.prio_en;
      insert_idle_en_o <= en_if.idle_en;
      accel_en_o <= en_if.accel_en;
      link_clk_gate_bypass_o <= ctl_q[PMLC_B_LGATE];
      host_clk_gate_bypass_o <= ctl_q[PMLC_B_HGATE];
      keep_clk_run_o <= ctl_q[PMLC_B_KEEP];
    end
  end

  // capability outputs follow the sticky bits, also not reset
  always_ff @(posedge clk_i) begin
    wake_from_cold_off_cap_o <= cap_q[PMLC_B_COLD];
    wake_from_doze_two_cap_o <= cap_q[PMLC_B_WD2];
    doze_two_state_cap_o <= cap_q[PMLC_B_D2];
    // format codes are fixed; flopped only so every pin leaves a register
    ts_fmt_audio_o <= PMLC_FMT_AUDIO;
    ts_fmt_video_o <= PMLC_FMT_VIDEO;
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  // answer-cycle sequences of the bus; write lane one holds the capability bits
  sequence s_wr_misc;
    avs_write_i && !avs_waitrequest_o && hit_misc && avs_byteenable_i[1];
  endsequence
  sequence s_wr_misc_lo;
    avs_write_i && !avs_waitrequest_o && hit_misc && avs_byteenable_i[0];
  endsequence
  sequence s_rd_misc;
    avs_read_i && !avs_waitrequest_o && hit_misc;
  endsequence
  sequence s_rd_link;
    avs_read_i && !avs_waitrequest_o && hit_link;
  endsequence
  // reserved bits checked on what the bus really returns, not on the mask
  property p_rsvd_zero;
    @(posedge clk_i) disable iff (reset_i)
      s_rd_misc |-> (avs_readdata_o & ~PMLC_MISC_WMASK) == 32'h0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("misc reserved bit set");
  // link register reserved bits on readback
  property p_link_rsvd;
    @(posedge clk_i) disable iff (reset_i)
      s_rd_link |-> (avs_readdata_o & ~PMLC_LINK_WMASK) == 32'h0;
  endproperty
  a_link_rsvd: assert property (p_link_rsvd) else $error("link reserved bit set");
  // readback and capability pins come from the same cap_q sample
  property p_cap_read;
    @(posedge clk_i) disable iff (reset_i)
      s_rd_misc |-> avs_readdata_o[PMLC_B_COLD] == wake_from_cold_off_cap_o
                    && avs_readdata_o[PMLC_B_WD2] == wake_from_doze_two_cap_o
                    && avs_readdata_o[PMLC_B_D2] == doze_two_state_cap_o;
  endproperty
  a_cap_read: assert property (p_cap_read) else $error("cap field vs readback");
  property p_cold_cap;
    @(posedge clk_i) disable iff (reset_i)
      s_wr_misc ##2 1'b1 |-> wake_from_cold_off_cap_o == $past(avs_writedata_i[15], 2);
  endproperty
  a_cold_cap: assert property (p_cold_cap) else $error("cold cap not updated");
  property p_wd2_cap;
    @(posedge clk_i) disable iff (reset_i)
      s_wr_misc |=> cap_q[PMLC_B_WD2] == $past(avs_writedata_i[13]);
  endproperty
  a_wd2_cap: assert property (p_wd2_cap) else $error("doze wake cap wrong");
  property p_d2_cap;
    @(posedge clk_i) disable iff (reset_i)
      ##1 doze_two_state_cap_o == $past(cap_q[PMLC_B_D2]);
  endproperty
  a_d2_cap: assert property (p_d2_cap) else $error("doze cap mismatch");
  property p_sticky;
    @(posedge clk_i) (reset_i && sticky_init_q) |=> cap_q == $past(cap_q);
  endproperty
  a_sticky: assert property (p_sticky) else $error("cap bits lost on reset");
  property p_keep;
    @(posedge clk_i) disable iff (reset_i)
      ctl_q[PMLC_B_KEEP] [*2] |-> keep_clk_run_o;
  endproperty
  a_keep: assert property (p_keep) else $error("keep clock not driven");
  // spare bit returns to zero on either reset
  property p_rsv3;
    @(posedge clk_i) (reset_i || pm_int_reset_i) |=> !ctl_q[PMLC_B_RSV3];
  endproperty
  a_rsv3: assert property (p_rsv3) else $error("spare bit not cleared");
  // a low-lane write reaches the gate bypass pins two edges later
  property p_lgate;
    @(posedge clk_i) disable iff (reset_i || pm_int_reset_i)
      s_wr_misc_lo ##2 1'b1
        |-> link_clk_gate_bypass_o == $past(avs_writedata_i[PMLC_B_LGATE], 2);
  endproperty
  a_lgate: assert property (p_lgate) else $error("link gate bypass wrong");
  property p_hgate;
    @(posedge clk_i) disable iff (reset_i || pm_int_reset_i)
      s_wr_misc_lo ##2 1'b1
        |-> host_clk_gate_bypass_o == $past(avs_writedata_i[PMLC_B_HGATE], 2);
  endproperty
  a_hgate: assert property (p_hgate) else $error("host gate bypass wrong");
  property p_gate_off;
    @(posedge clk_i) disable iff (reset_i)
      !phy_enhance_master_en_i |=> !accel_en_o && !insert_idle_en_o && !audio_timestamp_enh_en_o;
  endproperty
  a_gate_off: assert property (p_gate_off) else $error("enhancement active w/o enable");
  // with the master enable up, the timestamp pins follow the stored enables
  property p_ts_on;
    @(posedge clk_i) disable iff (reset_i)
      phy_enhance_master_en_i |=> audio_timestamp_enh_en_o == $past(link_q[PMLC_B_AUDIO])
                                  && video_timestamp_enh_en_o == $past(link_q[PMLC_B_VIDEO]);
  endproperty
  a_ts_on: assert property (p_ts_on) else $error("timestamp enable lost");
  // threshold field passes through unless a retry holds store-and-forward
  property p_thr_sel;
    @(posedge clk_i) disable iff (reset_i)
      phy_enhance_master_en_i && !retry_q
        |=> tx_thresh_o == $past(link_q[PMLC_B_THR_HI:PMLC_B_THR_LO]);
  endproperty
  a_thr_sel: assert property (p_thr_sel) else $error("threshold not applied");
  property p_retry;
    @(posedge clk_i) disable iff (reset_i || pm_int_reset_i)
      underrun_i |=> ##1 tx_thresh_o == PMLC_THR_2K;
  endproperty
  a_retry: assert property (p_retry) else $error("retry not store-and-forward");
  property p_eep;
    @(posedge clk_i) disable iff (reset_i || pm_int_reset_i)
      eep_load_i |=> link_q == ($past(eep_data_i) & PMLC_LINK_WMASK);
  endproperty
  a_eep: assert property (p_eep) else $error("eeprom load missed");
  property p_wait;
    @(posedge clk_i) disable iff (reset_i)
      (avs_read_i || avs_write_i) |-> ##[0:1] !avs_waitrequest_o;
  endproperty
  a_wait: assert property (p_wait) else $error("no bus answer");
  // the answer stands one cycle only, so a held request is not taken twice
  property p_wait_one;
    @(posedge clk_i) disable iff (reset_i)
      !avs_waitrequest_o |=> avs_waitrequest_o;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("answer held too long");
endmodule : pmlc_regs

// ===== testbench/pmlc_regs_tb_top.sv
// self-checking bench for the misc power/clock and link enhancement register bank
`timescale 1ns/1ps
module pmlc_regs_tb_top
  import pmlc_pkg::*;
;
  // ----------------------------------------
  // stimulus, model state and design
  // ----------------------------------------
  logic clk_i, reset_i, pm_int_reset_i, avs_read_i, avs_write_i, avs_waitrequest_o;
  logic eep_load_i, phy_enhance_master_en_i, underrun_i, tx_done_i;
  logic [7:0] avs_address_i;
  logic [3:0] avs_byteenable_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, eep_data_i, misc_m, link_m, seed, v;
  logic cold_o, doze_wake_o, doze_o, lgate_o, hgate_o, keep_o;
  logic audio_o, video_o, prio_o, idle_o, accel_o;
  logic [1:0] thr_o;
  logic [5:0] fmt_a_o, fmt_v_o;
  logic retry;
  int n_fail, comparisons, k;
  pmlc_regs u_pmlc_regs (.clk_i(clk_i), .reset_i(reset_i), .pm_int_reset_i(pm_int_reset_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .eep_load_i(eep_load_i), .eep_data_i(eep_data_i),
    .phy_enhance_master_en_i(phy_enhance_master_en_i), .underrun_i(underrun_i),
    .tx_done_i(tx_done_i), .wake_from_cold_off_cap_o(cold_o),
    .wake_from_doze_two_cap_o(doze_wake_o), .doze_two_state_cap_o(doze_o),
    .link_clk_gate_bypass_o(lgate_o), .host_clk_gate_bypass_o(hgate_o),
    .keep_clk_run_o(keep_o), .tx_thresh_o(thr_o), .audio_timestamp_enh_en_o(audio_o),
    .video_timestamp_enh_en_o(video_o), .ts_fmt_audio_o(fmt_a_o), .ts_fmt_video_o(fmt_v_o),
    .async_prio_en_o(prio_o), .insert_idle_en_o(idle_o), .accel_en_o(accel_o));
  // free-running 40 mhz clock
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic results;
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one avalon transfer; held until waitrequest is sampled low, bounded wait
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] rd);
    int i;
    @(posedge clk_i);
    avs_write_i <= wr;
    avs_read_i <= ~wr;
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_byteenable_i <= be;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_i);
      if (avs_waitrequest_o === 1'b0) break;
    end
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    if (i == 20) begin
      n_fail++;
      $display("[ERR] waitrequest expected 0 seen 1");
      results();
    end
  endtask
  // write plus model update; lanes and writable masks both apply
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] m, x;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    bus(1'b1, a, d, be, x);
    if (a == PMLC_MISC_OFS) misc_m = (misc_m & ~(m & PMLC_MISC_WMASK)) | (d & m & PMLC_MISC_WMASK);
    if (a == PMLC_LINK_OFS) link_m = (link_m & ~(m & PMLC_LINK_WMASK)) | (d & m & PMLC_LINK_WMASK);
  endtask
  task automatic rd(input logic [7:0] a);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, 4'hf, x);
    chk("readdata", x, a == PMLC_MISC_OFS ? misc_m : a == PMLC_LINK_OFS ? link_m : 32'h0);
  endtask
  // outputs are registered, so let the write settle before looking
  task automatic outs;
    repeat (3) @(posedge clk_i);
    #1;
    chk("misc_outs", {26'h0, cold_o, doze_wake_o, doze_o, lgate_o, hgate_o, keep_o},
        {26'h0, misc_m[15], misc_m[13], misc_m[10], misc_m[2:0]});
    chk("link_outs", {25'h0, thr_o, audio_o, video_o, prio_o, idle_o, accel_o},
        phy_enhance_master_en_i ? {25'h0, retry ? 2'h0 : link_m[13:12], link_m[9:7], link_m[2:1]} : 32'h0);
    chk("fmt_codes", {20'h0, fmt_a_o, fmt_v_o}, 32'h00000400);
  endtask
  task automatic rst_pulse(input bit internal);
    @(posedge clk_i);
    if (internal) pm_int_reset_i <= 1'b1;
    else reset_i <= 1'b1;
    @(posedge clk_i);
    pm_int_reset_i <= 1'b0;
    reset_i <= 1'b0;
    misc_m = misc_m & 32'h0000a400;
    link_m = PMLC_LINK_RST;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {reset_i, pm_int_reset_i, avs_read_i, avs_write_i, eep_load_i} = 5'h10;
    {phy_enhance_master_en_i, underrun_i, tx_done_i, retry} = 4'h0;
    {avs_address_i, avs_byteenable_i, avs_writedata_i, eep_data_i} = '0;
    {n_fail, comparisons} = 0;
    seed = 32'he051;
    misc_m = PMLC_MISC_RST;
    link_m = PMLC_LINK_RST;
    repeat (16) @(posedge clk_i);
    reset_i <= 1'b0;
    rd(PMLC_MISC_OFS);
    rd(PMLC_LINK_OFS);
    wr(8'hf8, 32'hffffffff, 4'hf);
    rd(8'hf8);
    outs();
    $display("test reset_and_unmapped done");
    // lane masking: low lane clears controls only, lane one clears the capability bits
    wr(PMLC_MISC_OFS, 32'hffffffff, 4'hf);
    rd(PMLC_MISC_OFS);
    outs();
    wr(PMLC_MISC_OFS, 32'h0, 4'h1);
    outs();
    wr(PMLC_MISC_OFS, 32'h0, 4'h2);
    rd(PMLC_MISC_OFS);
    outs();
    // capability bits must survive both resets, controls must not
    for (k = 0; k < 2; k++) begin
      wr(PMLC_MISC_OFS, k ? 32'h0000a40f : 32'h0000840f, 4'hf);
      rst_pulse(k[0]);
      rd(PMLC_MISC_OFS);
      outs();
    end
    $display("test misc_config done");
    wr(PMLC_LINK_OFS, 32'hffffffff, 4'hf);
    rd(PMLC_LINK_OFS);
    outs();
    phy_enhance_master_en_i <= 1'b1;
    for (k = 0; k < 4; k++) begin
      wr(PMLC_LINK_OFS, (k << 12) | 32'h00000386, 4'hf);
      outs();
    end
    // underrun forces the store-and-forward threshold until the retry ends
    for (k = 0; k < 2; k++) begin
      @(posedge clk_i);
      if (k == 0) underrun_i <= 1'b1;
      else tx_done_i <= 1'b1;
      @(posedge clk_i);
      {underrun_i, tx_done_i} <= 2'h0;
      retry = (k == 0);
      outs();
    end
    $display("test link_gating done");
    // eeprom autoload fills the link register
    for (k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      @(posedge clk_i);
      eep_data_i <= seed;
      eep_load_i <= 1'b1;
      @(posedge clk_i);
      eep_load_i <= 1'b0;
      link_m = seed & PMLC_LINK_WMASK;
      rd(PMLC_LINK_OFS);
      outs();
    end
    $display("test eeprom_load done");
    for (k = 0; k < 24; k++) begin
      seed = lfsr(seed);
      v = lfsr(seed ^ 32'h5a5a0f0f);
      phy_enhance_master_en_i <= seed[8];
      wr(seed[1:0] == 2'h3 ? 8'hf8 : seed[0] ? PMLC_LINK_OFS : PMLC_MISC_OFS, v, seed[7:4]);
      rd(seed[1:0] == 2'h3 ? 8'hf8 : seed[0] ? PMLC_LINK_OFS : PMLC_MISC_OFS);
      outs();
    end
    $display("test random_access done");
    results();
  end
endmodule // pmlc_regs_tb_top
